/* File: hdl/flash_mode_guard.sv */
/*
  Protected mode-entry checker: a key write, then value, inverse, value.
  Assumes writes arrive as single-cycle strobes from the register slave.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_mode_guard (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       key_we_i,
  input  wire logic [7:0] key_data_i,
  input  wire logic       mode_we_i,
  input  wire logic [7:0] mode_data_i,
  output logic            self_prog_o,
  output logic            seq_error_o
);

  typedef struct packed {
    logic [1:0] step;
    logic [7:0] value;
    logic       self_prog;
    logic       error;
  } guard_t;

  guard_t s_r;
  guard_t s_nxt;

  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.error = 1'b0;
    if (key_we_i)
    begin
      s_nxt.step = (key_data_i == flash_seq_pkg::PROTECT_KEY) ? 2'd1 : 2'd0;
    end
    else if (mode_we_i)
    begin
      case (s_r.step)
        2'd1:
        begin
          s_nxt.value = mode_data_i;
          s_nxt.step  = 2'd2;
        end
        2'd2:
        begin
          s_nxt.step  = (mode_data_i == ~s_r.value) ? 2'd3 : 2'd0;
          s_nxt.error = (mode_data_i != ~s_r.value);
        end
        2'd3:
        begin
          s_nxt.step = 2'd0;
          if (mode_data_i == s_r.value)
          begin
            s_nxt.self_prog = (s_r.value == flash_seq_pkg::MODE_SELF_PROG);
          end
          else
          begin
            s_nxt.error = 1'b1;
          end
        end
        default:
        begin
          s_nxt.error = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign self_prog_o = s_r.self_prog;
  assign seq_error_o = s_r.error;

endmodule : flash_mode_guard
`default_nettype wire

/* File: hdl/flash_self_program_verify.sv */
/*
  Flash self-programming sequencer with internal verify over a block or
  a range, plus erase, blank check and byte write, reached over Avalon-MM.
  Assumes a flash array port that answers a read in ACCESS_CYCLES cycles,
  and that the CPU writes the halt register to model the HALT launch.
*/
// Summary of operation
// - code 01h verifies ptr_low to cmp_low like 02h, no writes
// - code 02h verifies only the addressed span
// - range covers first to last inclusive
// - halt launches command, stall until end
// - bit1 verify error, bit2 write/erase error
// - status zero means normal completion
// - commands chain within one mode session
// - keyed protected entry, error in bit0
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_verify #(
  parameter int BLOCK_W = 8
) (
  input  wire logic                clock_i,
  input  wire logic                rst_i,
  input  wire logic [5:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  output logic      [BLOCK_W+7:0]  flash_addr_o,
  output logic                     flash_rd_o,
  output logic                     flash_wr_o,
  output logic                     flash_erase_o,
  output logic      [7:0]          flash_wdata_o,
  input  wire logic [7:0]          flash_rdata_i,
  input  wire logic [7:0]          flash_ref_i,
  output logic                     cpu_stall_o,
  output logic                     self_prog_o
);

  initial
  begin
    if (BLOCK_W < 1 || BLOCK_W > 8)
      $error("BLOCK_W must be 1 to 8");
  end

  typedef struct packed {
    logic [7:0]                command;
    logic [7:0]                ptr_high;
    logic [7:0]                ptr_low;
    logic [7:0]                cmp_high;
    logic [7:0]                cmp_low;
    logic [7:0]                wdata;
    logic [2:0]                status;
    flash_seq_pkg::seq_state_t state;
    logic [7:0]                addr;
    logic [1:0]                wait_cnt;
    logic                      ack;
    logic [31:0]               rdata;
  } seq_t;

  seq_t s_r;
  seq_t s_nxt;

  logic [3:0] reg_sel;
  logic       bus_req;
  logic       wr_hit;
  logic       guard_self_prog;
  logic       guard_error;
  logic       busy;

  assign reg_sel = avs_address[5:2];
  assign bus_req = (avs_read | avs_write) & ~s_r.ack;
  assign wr_hit  = avs_write & ~s_r.ack & avs_byteenable[0];
  assign busy    = (s_r.state != flash_seq_pkg::SEQ_IDLE);

  flash_mode_guard u_guard (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .key_we_i    (wr_hit && reg_sel == flash_seq_pkg::OFS_PROTECT),
    .key_data_i  (avs_writedata[7:0]),
    .mode_we_i   (wr_hit && reg_sel == flash_seq_pkg::OFS_MODE_CTRL),
    .mode_data_i (avs_writedata[7:0]),
    .self_prog_o (guard_self_prog),
    .seq_error_o (guard_error)
  );

  always_comb
  begin
    s_nxt     = s_r;
    s_nxt.ack = bus_req;
    // register writes
    if (wr_hit)
    begin
      case (reg_sel)
        flash_seq_pkg::OFS_COMMAND:   s_nxt.command  = avs_writedata[7:0];
        flash_seq_pkg::OFS_PTR_HIGH:  s_nxt.ptr_high = avs_writedata[7:0];
        flash_seq_pkg::OFS_PTR_LOW:   s_nxt.ptr_low  = avs_writedata[7:0];
        flash_seq_pkg::OFS_CMP_HIGH:  s_nxt.cmp_high = avs_writedata[7:0];
        flash_seq_pkg::OFS_CMP_LOW:   s_nxt.cmp_low  = avs_writedata[7:0];
        flash_seq_pkg::OFS_STATUS:    s_nxt.status   = avs_writedata[2:0];
        flash_seq_pkg::OFS_BUSY:      s_nxt.wdata    = avs_writedata[7:0];
        default:                      s_nxt.status   = s_nxt.status;
      endcase
    end
    // halt launches the loaded command
    if (wr_hit && reg_sel == flash_seq_pkg::OFS_HALT && !busy && guard_self_prog)
    begin
      s_nxt.addr = s_r.ptr_low;
      if (s_r.cmp_high != s_r.ptr_high || s_r.ptr_low > s_r.cmp_low)
      begin
        s_nxt.status[flash_seq_pkg::ST_WR_ER_ERR] = 1'b1;
        s_nxt.state = flash_seq_pkg::SEQ_DONE;
      end
      else
      begin
        case (s_r.command)
          flash_seq_pkg::CMD_VERIFY_BLK,
          flash_seq_pkg::CMD_VERIFY_RNG,
          flash_seq_pkg::CMD_BLANK:   s_nxt.state = flash_seq_pkg::SEQ_READ;
          flash_seq_pkg::CMD_ERASE,
          flash_seq_pkg::CMD_WRITE:   s_nxt.state = flash_seq_pkg::SEQ_WRITE;
          default:
          begin
            s_nxt.status[flash_seq_pkg::ST_WR_ER_ERR] = 1'b1;
            s_nxt.state = flash_seq_pkg::SEQ_DONE;
          end
        endcase
      end
      s_nxt.wait_cnt = 2'(flash_seq_pkg::ACCESS_CYCLES - 1);
    end
    if (guard_error)
      s_nxt.status[flash_seq_pkg::ST_SEQ_ERR] = 1'b1;
    // sequencer
    case (s_r.state)
      flash_seq_pkg::SEQ_IDLE:
      begin
        s_nxt.wait_cnt = s_nxt.wait_cnt;
      end
      flash_seq_pkg::SEQ_READ:
      begin
        if (s_r.wait_cnt == 2'd0)
          s_nxt.state = flash_seq_pkg::SEQ_CHECK;
        else
          s_nxt.wait_cnt = s_r.wait_cnt - 2'd1;
      end
      flash_seq_pkg::SEQ_CHECK:
      begin
        if ((s_r.command == flash_seq_pkg::CMD_BLANK && flash_rdata_i != flash_seq_pkg::BLANK_BYTE)
            || (s_r.command != flash_seq_pkg::CMD_BLANK && flash_rdata_i != flash_ref_i))
          s_nxt.status[flash_seq_pkg::ST_VERIFY_ERR] = 1'b1;
        if (s_r.addr == s_r.cmp_low)
          s_nxt.state = flash_seq_pkg::SEQ_DONE;
        else
        begin
          s_nxt.addr     = s_r.addr + 8'h01;
          s_nxt.wait_cnt = 2'(flash_seq_pkg::ACCESS_CYCLES - 1);
          s_nxt.state    = flash_seq_pkg::SEQ_READ;
        end
      end
      flash_seq_pkg::SEQ_WRITE:
      begin
        if (s_r.wait_cnt == 2'd0)
          s_nxt.state = flash_seq_pkg::SEQ_DONE;
        else
          s_nxt.wait_cnt = s_r.wait_cnt - 2'd1;
      end
      flash_seq_pkg::SEQ_DONE:
      begin
        s_nxt.state = flash_seq_pkg::SEQ_IDLE;
      end
      default:
      begin
        s_nxt.state = flash_seq_pkg::SEQ_IDLE;
      end
    endcase
    // read mux
    s_nxt.rdata = 32'h0000_0000;
    case (reg_sel)
      flash_seq_pkg::OFS_COMMAND:   s_nxt.rdata[7:0] = s_r.command;
      flash_seq_pkg::OFS_PTR_HIGH:  s_nxt.rdata[7:0] = s_r.ptr_high;
      flash_seq_pkg::OFS_PTR_LOW:   s_nxt.rdata[7:0] = s_r.ptr_low;
      flash_seq_pkg::OFS_CMP_HIGH:  s_nxt.rdata[7:0] = s_r.cmp_high;
      flash_seq_pkg::OFS_CMP_LOW:   s_nxt.rdata[7:0] = s_r.cmp_low;
      flash_seq_pkg::OFS_STATUS:    s_nxt.rdata[2:0] = s_r.status;
      flash_seq_pkg::OFS_MODE_CTRL: s_nxt.rdata[0]   = guard_self_prog;
      flash_seq_pkg::OFS_HALT:      s_nxt.rdata[0]   = busy;
      default:                      s_nxt.rdata      = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      s_r       <= '0;
      s_r.state <= flash_seq_pkg::SEQ_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  assign avs_readdata    = s_r.rdata;
  assign avs_waitrequest = (avs_read | avs_write) & ~s_r.ack;
  assign flash_addr_o    = {s_r.ptr_high[BLOCK_W-1:0], s_r.addr};
  assign flash_rd_o      = (s_r.state == flash_seq_pkg::SEQ_READ);
  assign flash_wr_o      = (s_r.state == flash_seq_pkg::SEQ_WRITE)
                           && (s_r.command == flash_seq_pkg::CMD_WRITE);
  assign flash_erase_o   = (s_r.state == flash_seq_pkg::SEQ_WRITE)
                           && (s_r.command == flash_seq_pkg::CMD_ERASE);
  assign flash_wdata_o   = s_r.wdata;
  assign cpu_stall_o     = busy;
  assign self_prog_o     = guard_self_prog;

  AST_VERIFY_NO_WRITE: assert property (@(posedge clock_i) disable iff (rst_i)
    (s_r.command == flash_seq_pkg::CMD_VERIFY_BLK || s_r.command == flash_seq_pkg::CMD_VERIFY_RNG)
    |-> !(flash_wr_o || flash_erase_o))
    else $error("verify command drove a write or erase");
  AST_RANGE_BOUND: assert property (@(posedge clock_i) disable iff (rst_i)
    flash_rd_o |-> (s_r.addr <= s_r.cmp_low))
    else $error("verify read outside range");
  AST_LAST_BYTE: assert property (@(posedge clock_i) disable iff (rst_i)
    (s_r.state == flash_seq_pkg::SEQ_CHECK && s_r.addr == s_r.cmp_low)
    |=> s_r.state == flash_seq_pkg::SEQ_DONE)
    else $error("range end not inclusive");
  AST_STALL_ENDS: assert property (@(posedge clock_i) disable iff (rst_i)
    (s_r.state == flash_seq_pkg::SEQ_DONE) |=> !cpu_stall_o)
    else $error("stall held past command end");
  AST_VERIFY_FLAG: assert property (@(posedge clock_i) disable iff (rst_i)
    (s_r.state == flash_seq_pkg::SEQ_CHECK && s_r.command != flash_seq_pkg::CMD_BLANK
     && flash_rdata_i != flash_ref_i) |=> s_r.status[flash_seq_pkg::ST_VERIFY_ERR])
    else $error("mismatch not flagged");
  AST_STATUS_STICKY: assert property (@(posedge clock_i) disable iff (rst_i)
    ($past(s_r.status[flash_seq_pkg::ST_VERIFY_ERR]) && !$past(wr_hit))
    |-> s_r.status[flash_seq_pkg::ST_VERIFY_ERR])
    else $error("error flag lost");
  AST_SEQ_ERR: assert property (@(posedge clock_i) disable iff (rst_i)
    guard_error |=> s_r.status[flash_seq_pkg::ST_SEQ_ERR])
    else $error("sequence error not flagged");
  AST_CHAIN: assert property (@(posedge clock_i) disable iff (rst_i)
    (s_r.state == flash_seq_pkg::SEQ_DONE) |=> self_prog_o == $past(self_prog_o))
    else $error("mode left by command end");

  // launch steps shared by the properties below
  sequence seq_halt_taken;
    wr_hit && reg_sel == flash_seq_pkg::OFS_HALT && !busy && guard_self_prog;
  endsequence

  sequence seq_halt_bad_ptr;
    wr_hit && reg_sel == flash_seq_pkg::OFS_HALT && !busy && guard_self_prog
    && (s_r.cmp_high != s_r.ptr_high || s_r.ptr_low > s_r.cmp_low);
  endsequence

  sequence seq_launch_read;
    wr_hit && reg_sel == flash_seq_pkg::OFS_HALT && !busy && guard_self_prog
    && s_r.cmp_high == s_r.ptr_high && s_r.ptr_low <= s_r.cmp_low
    && (s_r.command == flash_seq_pkg::CMD_VERIFY_BLK
        || s_r.command == flash_seq_pkg::CMD_VERIFY_RNG
        || s_r.command == flash_seq_pkg::CMD_BLANK);
  endsequence

  // two read wait cycles, then one compare
  sequence seq_byte_read;
    flash_rd_o [*2] ##1 (s_r.state == flash_seq_pkg::SEQ_CHECK);
  endsequence

  sequence seq_last_check;
    (s_r.state == flash_seq_pkg::SEQ_CHECK && s_r.addr == s_r.cmp_low)
    ##1 (s_r.state == flash_seq_pkg::SEQ_DONE);
  endsequence

  AST_HALT_STALLS: assert property (@(posedge clock_i) disable iff (rst_i)
    seq_halt_taken |=> cpu_stall_o)
    else $error("halt did not stall the cpu");
  AST_HALT_REFUSED: assert property (@(posedge clock_i) disable iff (rst_i)
    (wr_hit && reg_sel == flash_seq_pkg::OFS_HALT && !busy && !guard_self_prog)
    |=> !cpu_stall_o)
    else $error("halt launched outside self-programming mode");
  AST_BAD_POINTERS: assert property (@(posedge clock_i) disable iff (rst_i)
    seq_halt_bad_ptr
    |=> (s_r.status[flash_seq_pkg::ST_WR_ER_ERR] && s_r.state == flash_seq_pkg::SEQ_DONE))
    else $error("bad pointers not refused");
  AST_FIRST_BYTE: assert property (@(posedge clock_i) disable iff (rst_i)
    seq_launch_read |=> (s_r.addr == $past(s_r.ptr_low)))
    else $error("range does not start at first address");
  AST_READ_STEPS: assert property (@(posedge clock_i) disable iff (rst_i)
    seq_launch_read |=> seq_byte_read)
    else $error("byte read steps out of order");
  AST_RETURNS: assert property (@(posedge clock_i) disable iff (rst_i)
    seq_last_check |=> !cpu_stall_o)
    else $error("control not returned after last byte");

endmodule : flash_self_program_verify
`default_nettype wire

/* File: hdl/flash_seq_pkg.sv */
/*
  Package for the flash self-programming sequencer: register offsets,
  command codes, status bit positions, reset values and the mode keys.
  Assumes a single 125 MHz clock domain and a 32-bit Avalon-MM slave port.
*/
package flash_seq_pkg;

  // register word indices (avs_address[5:2])
  localparam logic [3:0] OFS_COMMAND    = 4'h0;
  localparam logic [3:0] OFS_PTR_HIGH   = 4'h1;
  localparam logic [3:0] OFS_PTR_LOW    = 4'h2;
  localparam logic [3:0] OFS_CMP_HIGH   = 4'h3;
  localparam logic [3:0] OFS_CMP_LOW    = 4'h4;
  localparam logic [3:0] OFS_STATUS     = 4'h5;
  localparam logic [3:0] OFS_PROTECT    = 4'h6;
  localparam logic [3:0] OFS_MODE_CTRL  = 4'h7;
  localparam logic [3:0] OFS_HALT       = 4'h8;
  localparam logic [3:0] OFS_BUSY       = 4'h9;
  localparam int         ADDR_W         = 6;

  // command codes
  localparam logic [7:0] CMD_NONE       = 8'h00;
  localparam logic [7:0] CMD_VERIFY_BLK = 8'h01;
  localparam logic [7:0] CMD_VERIFY_RNG = 8'h02;
  localparam logic [7:0] CMD_ERASE      = 8'h03;
  localparam logic [7:0] CMD_BLANK      = 8'h04;
  localparam logic [7:0] CMD_WRITE      = 8'h05;

  // status bits
  localparam int         ST_SEQ_ERR     = 0;
  localparam int         ST_VERIFY_ERR  = 1;
  localparam int         ST_WR_ER_ERR   = 2;

  // protected mode entry
  localparam logic [7:0] PROTECT_KEY    = 8'ha5;
  localparam logic [7:0] MODE_NORMAL    = 8'h00;
  localparam logic [7:0] MODE_SELF_PROG = 8'h01;

  // reset values and timing
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [7:0] BLANK_BYTE     = 8'hff;
  localparam int         ACCESS_CYCLES  = 2;

  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_READ,
    SEQ_CHECK,
    SEQ_WRITE,
    SEQ_DONE
  } seq_state_t;

endpackage : flash_seq_pkg

/* File: sim/flash_array_model.sv */
/*
  Behavioural flash array facing the sequencer's array port.
  Assumes one clock; a bad byte is injected only when the bench asks.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_array_model #(
  parameter int BLOCK_W = 2
) (
  input  wire logic               clock_i,
  input  wire logic               rst_i,
  input  wire logic [BLOCK_W+7:0] addr_i,
  input  wire logic               wr_i,
  input  wire logic               erase_i,
  input  wire logic [7:0]         wdata_i,
  input  wire logic [BLOCK_W+7:0] bad_addr_i,
  input  wire logic               bad_en_i,
  output logic      [7:0]         rdata_o,
  output logic      [7:0]         ref_o
);
  logic [7:0] mem [0:(1<<(BLOCK_W+8))-1];
  logic       wr_d;
  logic       er_d;

  initial
  begin
    for (int i = 0; i < (1<<(BLOCK_W+8)); i++)
      mem[i] = i[7:0] ^ 8'h5a;
  end

  // act once per write or erase pulse
  always @(posedge clock_i)
  begin
    wr_d <= wr_i & ~rst_i;
    er_d <= erase_i & ~rst_i;
    if (wr_i && !wr_d)
      mem[addr_i] <= wdata_i;
    if (erase_i && !er_d)
      for (int i = 0; i < 256; i++)
        mem[{addr_i[BLOCK_W+7:8], i[7:0]}] <= 8'hff;
  end

  assign rdata_o = mem[addr_i];
  // reference differs only at the commanded bad byte
  assign ref_o   = mem[addr_i] ^ {7'h00, bad_en_i && addr_i == bad_addr_i};
endmodule : flash_array_model
`default_nettype wire

/* File: sim/tb_top.sv */
/*
  Self-checking bench for the flash sequencer, driving Avalon-MM as the CPU.
  Assumes the array model beside it and one 125 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int BW = 2;
  logic          clock_i = 1'b0;
  logic          rst_i = 1'b1;
  logic [5:0]    avs_address = 6'h00;
  logic          avs_read = 1'b0;
  logic          avs_write = 1'b0;
  logic [31:0]   avs_writedata = 32'h0;
  logic [31:0]   avs_readdata;
  logic          avs_waitrequest, fl_rd, fl_wr, fl_er, cpu_stall, self_prog;
  logic [BW+7:0] fl_addr, rd_min, rd_max;
  logic [BW+7:0] bad_addr = '0;
  logic          bad_en = 1'b0;
  logic          wr_seen = 1'b0;
  logic [7:0]    fl_wdata, fl_rdata, fl_ref, lo, hi;
  logic [BW-1:0] blk;
  logic [31:0]   exp_q[$];
  int            err_total = 0;
  int            tests_run = 0;

  always #4 clock_i = ~clock_i;

  flash_self_program_verify #(.BLOCK_W(BW)) dut (.clock_i(clock_i), .rst_i(rst_i),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .flash_addr_o(fl_addr), .flash_rd_o(fl_rd),
    .flash_wr_o(fl_wr), .flash_erase_o(fl_er), .flash_wdata_o(fl_wdata),
    .flash_rdata_i(fl_rdata), .flash_ref_i(fl_ref), .cpu_stall_o(cpu_stall),
    .self_prog_o(self_prog));

  flash_array_model #(.BLOCK_W(BW)) array (.clock_i(clock_i), .rst_i(rst_i),
    .addr_i(fl_addr), .wr_i(fl_wr), .erase_i(fl_er), .wdata_i(fl_wdata),
    .bad_addr_i(bad_addr), .bad_en_i(bad_en), .rdata_o(fl_rdata), .ref_o(fl_ref));

  task automatic complete_run();
    $display("tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bus(input logic rd, input logic [3:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    avs_read      <= rd;
    avs_write     <= !rd;
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {24'($urandom), d};
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0)
    begin
      err_total++;
      complete_run();
    end
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    bus(1'b0, idx, d);
  endtask : wr

  task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus(1'b1, idx, 8'h00);
  endtask : rd

  // read results are compared in arrival order
  always @(posedge clock_i)
    if (avs_read && avs_waitrequest === 1'b0)
    begin
      if (exp_q.size() == 0)
        chk("unnoted read", 32'h1, 32'h0);
      else
        chk("readdata", exp_q.pop_front(), avs_readdata);
    end

  always @(posedge clock_i)
  begin
    if (fl_rd && fl_addr < rd_min)
      rd_min = fl_addr;
    if (fl_rd && fl_addr > rd_max)
      rd_max = fl_addr;
    if (fl_wr || fl_er)
      wr_seen = 1'b1;
  end

  task automatic mode(input logic [7:0] v, input logic [7:0] inv);
    // no interrupt sources reach the block
    wr(4'h6, 8'ha5);
    wr(4'h7, v);
    wr(4'h7, inv);
    wr(4'h7, v);
    repeat (3) @(negedge clock_i);
    $display("test mode %h done", v);
  endtask : mode

  task automatic run_cmd(input logic [7:0] cmd, input logic [BW-1:0] bc,
                         input logic [7:0] l, input logic [7:0] h, input logic [7:0] st);
    int n;
    n = 0;
    wr(4'h0, cmd);
    wr(4'h1, 8'(blk));
    wr(4'h2, l);
    wr(4'h3, 8'(bc));
    wr(4'h4, h);
    wr(4'h5, 8'h00);
    rd_min = '1;
    rd_max = '0;
    wr_seen = 1'b0;
    // watchdog restart skipped, no watchdog here
    wr(4'h8, 8'h01);
    @(negedge clock_i);
    while (cpu_stall !== 1'b0 && n < 3000)
    begin
      @(negedge clock_i);
      n++;
    end
    if (cpu_stall !== 1'b0)
    begin
      err_total++;
      complete_run();
    end
    rd(4'h5, {24'h0, st});
    $display("test command %h done", cmd);
  endtask : run_cmd

  initial
  begin
    void'($urandom(30675));
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(4'h5, 32'h0);
    rd(4'h7, 32'h0);
    wr(4'h8, 8'h01);
    repeat (4) @(negedge clock_i);
    chk("stall outside mode", 32'h0, 32'(cpu_stall));
    mode(8'h01, 8'h00);
    rd(4'h5, 32'h1);
    chk("self_prog", 32'h0, 32'(self_prog));
    wr(4'h5, 8'h00);
    mode(8'h01, 8'hfe);
    chk("self_prog", 32'h1, 32'(self_prog));
    rd(4'h7, 32'h1);
    blk = BW'($urandom);
    run_cmd(8'h01, blk, 8'h00, 8'hff, 8'h00);
    chk("first read", 32'({blk, 8'h00}), 32'(rd_min));
    chk("last read", 32'({blk, 8'hff}), 32'(rd_max));
    chk("array touched", 32'h0, 32'(wr_seen));
    lo = 8'($urandom_range(1, 100));
    hi = 8'($urandom_range(150, 255));
    run_cmd(8'h02, blk, lo, hi, 8'h00);
    chk("first read", 32'({blk, lo}), 32'(rd_min));
    chk("last read", 32'({blk, hi}), 32'(rd_max));
    bad_addr <= {blk, hi};
    bad_en <= 1'b1;
    run_cmd(8'h02, blk, lo, hi, 8'h02);
    bad_addr <= {blk, lo - 8'h01};
    run_cmd(8'h02, blk, lo, hi, 8'h00);
    bad_en <= 1'b0;
    run_cmd(8'h03, blk, 8'h00, 8'h00, 8'h00);
    run_cmd(8'h04, blk, 8'h00, 8'hff, 8'h00);
    lo = 8'($urandom);
    hi = 8'($urandom_range(0, 254));
    wr(4'h9, hi);
    run_cmd(8'h05, blk, lo, lo, 8'h00);
    chk("written byte", {24'h0, hi}, {24'h0, array.mem[{blk, lo}]});
    run_cmd(8'h04, blk, lo, lo, 8'h02);
    run_cmd(8'h01, blk + 1'b1, 8'h00, 8'hff, 8'h04);
    run_cmd(8'h07, blk, 8'h00, 8'hff, 8'h04);
    mode(8'h00, 8'hff);
    chk("self_prog", 32'h0, 32'(self_prog));
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
